// >>> hdl/lcc_top.sv
// Logic cell control stage with APB register access
// Summary of operation
// (R1) The cell runs only while its enable bit is set.
// (R2) Bit 6 of the control register drives the cell output onto its pin; here the pin is driven only while enable bit 7 is also set.
// (R3) Bit 5 is read-only and returns the cell output after inversion.
// (R4) With bit 4 set every rising output edge sets the event flag.
// (R5) With bit 3 set every falling output edge sets the event flag.
// (R6) The event flag stays until software clears it; a new edge wins.
// (R7) Bits 2 to 0 select one of eight functions of the four gates.
// (R8) Code 000 ORs the product of gates 1,2 with that of gates 3,4.
// (R9) Code 010 is the AND of all four gates.
// (R10) Code 100 is a D flop with set and reset taken from gates.
// (R11) Code 101 is a D flop on two ANDed gates with a gate reset.
// (R12) Code 110 is a J-K flop with reset, all signals from gates.
// (R13) Code 111 is a transparent latch with set and reset from gates.
// (R14) Code 001 is OR-XOR and code 011 is a set-reset latch.
// (R15) Any reset clears the control register to zero.
// (R16) Control resets to zero, leaving the cell off and events disarmed.
//
// Added by the designer: the APB interface to the registers and the register offsets.
module lcc_top
	import lcc_pkg::*;
(
	// Clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// APB slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// Gate outputs from the gating stage, asynchronous
	input  wire logic [LCC_GATES-1:0] gate_in,
	// Cell output to other peripherals and its pin
	output logic                      cell_out,
	output logic                      cell_pin_out,
	output logic                      cell_pin_oe_n,
	// Event flag level
	output logic                      edge_event_flag
);

	typedef struct packed {
		logic                  cell_enable;
		logic                  pin_drive_enable;
		logic                  rise_event_enable;
		logic                  fall_event_enable;
		logic [LCC_FSEL_W-1:0] function_select;
		logic                  output_invert;
		logic                  event_flag;
		logic                  cell_out;
		logic                  out_prev;
		logic [31:0]           rdata;
	} lcc_top_s;

	lcc_top_s               st_ff;
	lcc_top_s               nxt_st;
	logic [LCC_GATES-1:0]   gate_sync;
	logic                   logic_val;
	logic                   setup_ph;
	logic                   access_ph;
	logic                   wr_lo;
	logic                   hit_ctrl;
	logic                   hit_cfg;
	logic                   hit_stat;
	logic                   rise_seen;
	logic                   fall_seen;
	logic [7:0]             ctrl_word;

	lcc_sync #(
		.W        (LCC_GATES)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (gate_in),
		.sync_out (gate_sync)
	);

	lcc_func u_func (
		.pclk            (pclk),
		.presetn         (presetn),
		.enable          (st_ff.cell_enable),
		.function_select (st_ff.function_select),
		.gate            (gate_sync),
		.logic_out       (logic_val)
	);

	// Bus decode
	assign setup_ph  = psel & ~penable;
	assign access_ph = psel & penable;
	assign hit_ctrl  = (paddr == LCC_OFS_CONTROL);
	assign hit_cfg   = (paddr == LCC_OFS_CONFIG);
	assign hit_stat  = (paddr == LCC_OFS_STATUS);
	// Only the low byte holds fields, so only its strobe matters
	assign wr_lo     = access_ph & pwrite & pstrb[0];

	// Assembled control word as software sees it
	always_comb begin
		ctrl_word                  = LCC_CONTROL_RST;
		ctrl_word[LCC_BIT_ENABLE]  = st_ff.cell_enable;
		// (R2) pin drive bit
		ctrl_word[LCC_BIT_PIN_DRIVE] = st_ff.pin_drive_enable;
		// (R3) live output readback
		ctrl_word[LCC_BIT_READBACK] = st_ff.cell_out;
		ctrl_word[LCC_BIT_RISE_EN] = st_ff.rise_event_enable;
		ctrl_word[LCC_BIT_FALL_EN] = st_ff.fall_event_enable;
		ctrl_word[LCC_FSEL_LSB +: LCC_FSEL_W] = st_ff.function_select;
	end

	always_comb begin
		nxt_st = st_ff;

		// Control register writes; readback bit ignores writes
		if (wr_lo && hit_ctrl) begin
			// (R1) enable bit
			nxt_st.cell_enable       = pwdata[LCC_BIT_ENABLE];
			nxt_st.pin_drive_enable  = pwdata[LCC_BIT_PIN_DRIVE];
			nxt_st.rise_event_enable = pwdata[LCC_BIT_RISE_EN];
			nxt_st.fall_event_enable = pwdata[LCC_BIT_FALL_EN];
			// (R7) function select field
			nxt_st.function_select   =
				pwdata[LCC_FSEL_LSB +: LCC_FSEL_W];
		end
		if (wr_lo && hit_cfg) begin
			nxt_st.output_invert = pwdata[LCC_BIT_INVERT];
		end

		// (R3) output sampled after inversion
		nxt_st.cell_out = st_ff.cell_enable &
			(logic_val ^ st_ff.output_invert);
		nxt_st.out_prev = st_ff.cell_out;

		// Inverting a running cell makes an edge, and so an event if that edge direction is armed
		rise_seen = st_ff.cell_out & ~st_ff.out_prev;
		fall_seen = ~st_ff.cell_out & st_ff.out_prev;

		// (R6) write one clears, checked before the set
		if (wr_lo && hit_stat && pwdata[LCC_BIT_EVENT]) begin
			nxt_st.event_flag = 1'b0;
		end
		// (R4) rising edge sets the flag
		if (rise_seen && st_ff.rise_event_enable) begin
			nxt_st.event_flag = 1'b1;
		end
		// (R5) falling edge sets the flag
		if (fall_seen && st_ff.fall_event_enable) begin
			nxt_st.event_flag = 1'b1;
		end

		// Read data is captured in the setup cycle
		if (setup_ph) begin
			nxt_st.rdata = 32'h0000_0000;
			if (hit_ctrl) begin
				nxt_st.rdata[7:0] = ctrl_word;
			end else if (hit_cfg) begin
				nxt_st.rdata[LCC_BIT_INVERT] = st_ff.output_invert;
			end else if (hit_stat) begin
				nxt_st.rdata[LCC_BIT_EVENT] = st_ff.event_flag;
				nxt_st.rdata[LCC_GATE_LSB +: LCC_GATES] = gate_sync;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// (R15) control cleared on reset
			st_ff.cell_enable       <= LCC_CONTROL_RST[LCC_BIT_ENABLE];
			st_ff.pin_drive_enable  <= LCC_CONTROL_RST[LCC_BIT_PIN_DRIVE];
			// (R16) events disarmed
			st_ff.rise_event_enable <= LCC_CONTROL_RST[LCC_BIT_RISE_EN];
			st_ff.fall_event_enable <= LCC_CONTROL_RST[LCC_BIT_FALL_EN];
			st_ff.function_select   <=
				LCC_CONTROL_RST[LCC_FSEL_LSB +: LCC_FSEL_W];
			st_ff.output_invert     <= LCC_INVERT_RST;
			st_ff.event_flag        <= 1'b0;
			st_ff.cell_out          <= 1'b0;
			st_ff.out_prev          <= 1'b0;
			st_ff.rdata             <= 32'h0000_0000;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// One wait-free access phase; read data already stands from setup
	assign pready  = 1'b1;
	assign pslverr = access_ph & ~(hit_ctrl | hit_cfg | hit_stat);
	assign prdata  = st_ff.rdata;

	assign cell_out        = st_ff.cell_out;
	assign cell_pin_out    = st_ff.cell_out;
	// (R2) pin driven only when enabled and drive bit set
	assign cell_pin_oe_n   = ~(st_ff.cell_enable & st_ff.pin_drive_enable);
	assign edge_event_flag = st_ff.event_flag;

endmodule : lcc_top

// >>> hdl/lcc_pkg.sv
// Constants shared by the logic cell control block
package lcc_pkg;

	// Register byte offsets
	localparam logic [11:0] LCC_OFS_CONTROL = 12'h000;
	localparam logic [11:0] LCC_OFS_CONFIG  = 12'h004;
	localparam logic [11:0] LCC_OFS_STATUS  = 12'h008;

	// Field positions in cell_control
	localparam int LCC_BIT_ENABLE    = 7;
	localparam int LCC_BIT_PIN_DRIVE = 6;
	localparam int LCC_BIT_READBACK  = 5;
	localparam int LCC_BIT_RISE_EN   = 4;
	localparam int LCC_BIT_FALL_EN   = 3;
	localparam int LCC_FSEL_LSB      = 0;
	localparam int LCC_FSEL_W        = 3;

	// Field positions in the config and status words
	localparam int LCC_BIT_INVERT    = 0;
	localparam int LCC_BIT_EVENT     = 0;
	localparam int LCC_GATE_LSB      = 4;
	localparam int LCC_GATES         = 4;

	// Reset values
	localparam logic [7:0]  LCC_CONTROL_RST = 8'h00;
	localparam logic        LCC_INVERT_RST  = 1'b0;

	// Function select codes
	localparam logic [2:0] LCC_FN_AND_OR   = 3'h0;
	localparam logic [2:0] LCC_FN_OR_XOR   = 3'h1;
	localparam logic [2:0] LCC_FN_AND4     = 3'h2;
	localparam logic [2:0] LCC_FN_SR_LATCH = 3'h3;
	localparam logic [2:0] LCC_FN_DFF_SR   = 3'h4;
	localparam logic [2:0] LCC_FN_DFF_R    = 3'h5;
	localparam logic [2:0] LCC_FN_JK_R     = 3'h6;
	localparam logic [2:0] LCC_FN_LATCH_SR = 3'h7;

	// Synchroniser depth for pin inputs
	localparam int LCC_SYNC_STAGES = 3;

endpackage : lcc_pkg

// >>> hdl/lcc_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree
module lcc_sync
	import lcc_pkg::*;
#(
	parameter int W = LCC_GATES
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Asynchronous inputs and filtered result
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] stable;
	} lcc_sync_s;

	lcc_sync_s st_ff;
	lcc_sync_s nxt_st;

	always_comb begin
		nxt_st    = st_ff;
		nxt_st.s1 = async_in;
		// Stage one feeds only stage two
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		for (int i = 0; i < W; i++) begin
			if (st_ff.s2[i] == st_ff.s3[i]) begin
				nxt_st.stable[i] = st_ff.s3[i];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign sync_out = st_ff.stable;

endmodule : lcc_sync

// >>> hdl/lcc_func.sv
// Eight selectable logic functions that combine the four gate levels
module lcc_func
	import lcc_pkg::*;
(
	// Clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// Control
	input  wire logic                  enable,
	input  wire logic [LCC_FSEL_W-1:0] function_select,
	// Gate levels, index 0 is gate 1
	input  wire logic [LCC_GATES-1:0]  gate,
	// Result before inversion
	output logic                       logic_out
);

	typedef struct packed {
		logic q;
		logic clk_prev;
	} lcc_func_s;

	lcc_func_s st_ff;
	lcc_func_s nxt_st;
	logic      comb_val;
	logic      seq_mode;
	logic      clk_rise;
	logic      s_in;
	logic      r_in;

	always_comb begin
		nxt_st          = st_ff;
		nxt_st.clk_prev = gate[0];
		clk_rise        = gate[0] & ~st_ff.clk_prev;
		s_in            = gate[3];
		r_in            = gate[2];
		comb_val        = 1'b0;
		seq_mode        = 1'b1;
		case (function_select)
			// (R8) AND-OR
			LCC_FN_AND_OR: begin
				comb_val = (gate[0] & gate[1]) | (gate[2] & gate[3]);
				seq_mode = 1'b0;
			end
			// (R14) OR-XOR
			LCC_FN_OR_XOR: begin
				comb_val = (gate[0] | gate[1]) ^ (gate[2] | gate[3]);
				seq_mode = 1'b0;
			end
			// (R9) four-input AND
			LCC_FN_AND4: begin
				comb_val = &gate;
				seq_mode = 1'b0;
			end
			// (R14) set-reset latch
			LCC_FN_SR_LATCH: begin
				if (gate[2] | gate[3]) begin
					nxt_st.q = 1'b0;
				end else if (gate[0] | gate[1]) begin
					nxt_st.q = 1'b1;
				end
			end
			// (R10) D flop with set and reset
			LCC_FN_DFF_SR: begin
				if (r_in) begin
					nxt_st.q = 1'b0;
				end else if (s_in) begin
					nxt_st.q = 1'b1;
				end else if (clk_rise) begin
					nxt_st.q = gate[1];
				end
			end
			// (R11) two-input D flop with reset
			LCC_FN_DFF_R: begin
				if (r_in) begin
					nxt_st.q = 1'b0;
				end else if (clk_rise) begin
					nxt_st.q = gate[1] & gate[3];
				end
			end
			// (R12) J-K flop with reset
			LCC_FN_JK_R: begin
				if (r_in) begin
					nxt_st.q = 1'b0;
				end else if (clk_rise) begin
					case ({gate[1], gate[3]})
						2'b10:   nxt_st.q = 1'b1;
						2'b01:   nxt_st.q = 1'b0;
						2'b11:   nxt_st.q = ~st_ff.q;
						default: nxt_st.q = st_ff.q;
					endcase
				end
			end
			// (R13) transparent latch with set and reset
			LCC_FN_LATCH_SR: begin
				if (r_in) begin
					nxt_st.q = 1'b0;
				end else if (s_in) begin
					nxt_st.q = 1'b1;
				end else if (gate[0]) begin
					nxt_st.q = gate[1];
				end
			end
			default: begin
				seq_mode = 1'b0;
			end
		endcase
		// (R1) disabled cell holds zero
		if (!enable) begin
			nxt_st.q = 1'b0;
		end
		// Set, reset and open latch act without waiting for a clock edge
		logic_out = enable & (seq_mode ? nxt_st.q : comb_val);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

endmodule : lcc_func

// >>> bench/lcc_props.sv
// Port-level assertions for the logic cell control block
module lcc_props
	import lcc_pkg::*;
(
	// Clock, reset and bus
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [11:0]          paddr,
	input wire logic [31:0]          pwdata,
	input wire logic [3:0]           pstrb,
	input wire logic [31:0]          prdata,
	input wire logic                 pready,
	input wire logic                 pslverr,
	// Cell side
	input wire logic [LCC_GATES-1:0] gate_in,
	input wire logic                 cell_out,
	input wire logic                 cell_pin_out,
	input wire logic                 cell_pin_oe_n,
	input wire logic                 edge_event_flag
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] ctl_ff;
	logic       wr;
	logic       arm;
	logic       clr;
	assign wr  = psel & penable & pwrite & pstrb[0];
	assign arm = ctl_ff[4] | ctl_ff[3];
	assign clr = wr && paddr == LCC_OFS_STATUS && pwdata[0];
	// Shadow of control, since the checker cannot see the register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) ctl_ff <= 8'h00;
		else if (wr && paddr == LCC_OFS_CONTROL) ctl_ff <= pwdata[7:0];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_pin_enable: assert property (cell_pin_oe_n == !(ctl_ff[7] && ctl_ff[6]))
		else $error("pin enable wrong");
	a_pin_copy: assert property (cell_pin_out == cell_out)
		else $error("pin level differs");
	a_off_low: assert property ((!ctl_ff[7])[*3] |-> !cell_out)
		else $error("disabled cell output high");
	a_read_ctl: assert property (psel && !penable && !pwrite && paddr == 0
		|=> prdata[7:0] == {$past(ctl_ff[7:6]), $past(cell_out),
		$past(ctl_ff[4:0])}) else $error("control read wrong");
	a_rise_flag: assert property (ctl_ff[4] && $rose(cell_out)
		|-> ##[1:3] edge_event_flag) else $error("rise not flagged");
	a_fall_flag: assert property (ctl_ff[3] && $fell(cell_out)
		|-> ##[1:3] edge_event_flag) else $error("fall not flagged");
	a_flag_armed: assert property ($rose(edge_event_flag)
		|-> $past(arm) || $past(arm, 2) || $past(arm, 3))
		else $error("flag set while disarmed");
	a_flag_hold: assert property (edge_event_flag && !clr |=> edge_event_flag)
		else $error("flag dropped");
	cover property ($rose(edge_event_flag));
	cover property (clr);
	cover property (!cell_pin_oe_n && cell_out);
endmodule : lcc_props

bind lcc_top lcc_props i_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.gate_in(gate_in), .cell_out(cell_out), .cell_pin_out(cell_pin_out),
	.cell_pin_oe_n(cell_pin_oe_n), .edge_event_flag(edge_event_flag)
);

// >>> bench/lcc_gate_src.sv
// Source of the four gate levels that feed the cell
module lcc_gate_src
	import lcc_pkg::*;
(
	// Level asked for by the bench
	input  wire logic [LCC_GATES-1:0] want,
	// Levels towards the cell
	output logic      [LCC_GATES-1:0] gate_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// Late change keeps the asynchronous levels off the clock edge
	// Runs once at time zero too, so the gates are known from 1.3 ns on
	always begin
		gate_out <= #1.3 want;
		@(want);
	end
endmodule : lcc_gate_src

// >>> bench/test_logic_cell_control.sv
// Self-checking bench for the logic cell control block
`define chk(n, e, g) begin \
	checked++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("unexpected %s exp %h got %h", n, e, g); \
	end \
end
module test_logic_cell_control
	import lcc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [3:0]  pstrb = 4'h1, want = 4'h0, gate_in;
	logic        pready, pslverr, cell_out, pin_out, oe_n, flag, err;
	int          failures = 0, checked = 0;
	lcc_gate_src i_src (.want(want), .gate_out(gate_in));
	lcc_top i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.gate_in(gate_in), .cell_out(cell_out), .cell_pin_out(pin_out),
		.cell_pin_oe_n(oe_n), .edge_event_flag(flag)
	);
	initial begin
		forever #2 pclk = ~pclk;
	end
	task automatic complete_run();
		if (failures == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel   <= 1'h1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (n >= 20) begin
			failures++;
			complete_run();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask : bus
	// Sync filter plus output flop take a handful of cycles
	task automatic settle();
		repeat (10) @(posedge pclk);
	endtask : settle
	task automatic t_reset();
		bus(1'h0, LCC_OFS_CONTROL, 32'h0000_0000);
		`chk("control", 32'h0000_0000, rd)
		bus(1'h1, LCC_OFS_CONTROL, 32'h0000_00DF);
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		bus(1'h0, LCC_OFS_CONTROL, 32'h0000_0000);
		`chk("control", 32'h0000_0000, rd)
	endtask : t_reset
	task automatic t_comb();
		logic [3:0] g;
		logic       e;
		for (int m = 0; m < 3; m++) begin
			bus(1'h1, LCC_OFS_CONTROL, 32'h0000_0080 | m);
			for (int i = 0; i < 16; i++) begin
				g = i[3:0];
				want <= g;
				settle();
				case (m)
					0: e = (g[0] & g[1]) | (g[2] & g[3]);
					1: e = (g[0] | g[1]) ^ (g[2] | g[3]);
					default: e = &g;
				endcase
				`chk("comb out", e, cell_out)
			end
		end
	endtask : t_comb
	// Each step packs the expected output above the four gate levels
	task automatic run(input logic [2:0] m, input logic [29:0] s);
		bus(1'h1, LCC_OFS_CONTROL, {24'h00_0000, 5'h10, m});
		for (int i = 5; i >= 0; i--) begin
			want <= s[i*5 +: 4];
			settle();
			`chk("seq out", s[i*5+4], cell_out)
		end
	endtask : run
	task automatic t_seq();
		run(3'h3, {5'h11, 5'h10, 5'h04, 5'h00, 5'h05, 5'h12});
		run(3'h4, {5'h04, 5'h02, 5'h13, 5'h10, 5'h04, 5'h18});
		run(3'h5, {5'h04, 5'h0A, 5'h1B, 5'h10, 5'h04, 5'h03});
		run(3'h6, {5'h04, 5'h02, 5'h13, 5'h10, 5'h18, 5'h09});
		run(3'h7, {5'h04, 5'h13, 5'h12, 5'h01, 5'h18, 5'h04});
	endtask : t_seq
	task automatic t_pin();
		want <= 4'h0;
		bus(1'h1, LCC_OFS_CONTROL, 32'h0000_00E0);
		settle();
		bus(1'h0, LCC_OFS_CONTROL, 32'h0000_0000);
		`chk("control", 32'h0000_00C0, rd)
		`chk("pin oe", 1'h0, oe_n)
		want <= 4'h3;
		settle();
		bus(1'h0, LCC_OFS_CONTROL, 32'h0000_0000);
		`chk("control", 32'h0000_00E0, rd)
		`chk("pin out", 1'h1, pin_out)
		bus(1'h1, LCC_OFS_CONFIG, 32'h0000_0001);
		settle();
		bus(1'h0, LCC_OFS_CONTROL, 32'h0000_0000);
		`chk("control", 32'h0000_00C0, rd)
		// Without inversion an enabled cell would show a one here
		bus(1'h1, LCC_OFS_CONFIG, 32'h0000_0000);
		bus(1'h1, LCC_OFS_CONTROL, 32'h0000_0040);
		pstrb <= 4'h0;
		bus(1'h1, LCC_OFS_CONTROL, 32'h0000_0080);
		pstrb <= 4'h1;
		`chk("slave error", 1'h0, err)
		bus(1'h1, 12'h00C, 32'h0000_0080);
		`chk("slave error", 1'h1, err)
		settle();
		`chk("cell out", 1'h0, cell_out)
		`chk("pin oe", 1'h1, oe_n)
	endtask : t_pin
	task automatic t_event();
		// Gates settle before enabling, so no stale level makes an edge
		want <= 4'h0;
		settle();
		bus(1'h1, LCC_OFS_CONTROL, 32'h0000_0088);
		bus(1'h1, LCC_OFS_STATUS, 32'h0000_0001);
		want <= 4'h3;
		settle();
		`chk("flag", 1'h0, flag)
		want <= 4'h0;
		settle();
		settle();
		`chk("flag", 1'h1, flag)
		bus(1'h1, LCC_OFS_CONTROL, 32'h0000_0090);
		bus(1'h1, LCC_OFS_STATUS, 32'h0000_0001);
		settle();
		`chk("flag", 1'h0, flag)
		want <= 4'h3;
		settle();
		`chk("flag", 1'h1, flag)
		bus(1'h1, LCC_OFS_STATUS, 32'h0000_0001);
		want <= 4'h0;
		settle();
		`chk("flag", 1'h0, flag)
		// Clear lands on the edge at which the rise is seen
		want <= 4'h3;
		repeat (3) @(posedge pclk);
		bus(1'h1, LCC_OFS_STATUS, 32'h0000_0001);
		settle();
		`chk("flag", 1'h1, flag)
	endtask : t_event
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		t_reset();
		t_comb();
		t_seq();
		t_pin();
		t_event();
		complete_run();
	end
endmodule : test_logic_cell_control
